// file: rtl/hc_regs_consts.vh
/*
 * Constants for the low-speed threshold and first root hub descriptor
 * register bank: command codes, field positions, reset values, timing.
 * Assumes it is included by bare name from rtl/ design files.
 */
`ifndef HC_REGS_CONSTS_VH
`define HC_REGS_CONSTS_VH

`define CMD_LST_READ      8'h11
`define CMD_LST_WRITE     8'h91
`define CMD_RHA_READ      8'h12
`define CMD_RHA_WRITE     8'h92

`define LST_RESET         11'h628
`define LST_MSB           10

`define RHA_SETTLE_MSB    31
`define RHA_SETTLE_LSB    24
`define RHA_OC_ABSENT     12
`define RHA_OC_PER_PORT   11
`define RHA_COMPOUND      10
`define RHA_PWR_ABSENT    9
`define RHA_PWR_PER_PORT  8
`define RHA_PORTS_MSB     1

`define RHA_SETTLE_RESET  8'hFF
`define RHA_OC_ABS_RESET  1'h0
`define RHA_PWR_ABS_RESET 1'h0
`define RHA_PSM_RESET     1'h1
`define RHA_PORTS_VALUE   2'h2

`define SETTLE_UNIT_MS    2

`endif

// file: rtl/ls_commit_gate.v
/*
 * Low-speed commit gate: compares frame bits left with the threshold.
 * Assumes bits-left is a 14-bit count in controller clock domain.
 */
`timescale 1ns/10ps
`include "hc_regs_consts.vh"

module ls_commit_gate (
    input  wire        clock,
    input  wire        rst,
    input  wire        clk_en,
    input  wire [13:0] frame_bits_left,
    input  wire [10:0] threshold,
    input  wire        ls_request,
    output reg         ls_start_r
);

    reg ls_start_nxt;

    ////////////////////////////////////////////////////////////////////
    // Start only when enough bit times remain to finish the packet
    always @* begin
        ls_start_nxt = ls_request &&
            (frame_bits_left >= {3'h0, threshold});
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ls_start_r <= 1'b0;
        end else if (clk_en) begin
            ls_start_r <= ls_start_nxt;
        end
    end

endmodule

// file: rtl/hc_ls_threshold_roothub_desc.v
/*
 * Register bank for the low-speed commit threshold and the first root
 * hub descriptor, reached by command codes with 32-bit data, plus the
 * gate that lets a low-speed transaction start only when enough bit
 * times are left in the frame.
 * Assumes cmd_valid is a one-cycle strobe with cmd_code and wr_data
 * valid in the same cycle, all synchronous to clock. Assumes the
 * frame counter counts down in bit times in this same clock domain.
 * The threshold takes one write after each reset and then locks; a
 * driver that must change it has to reset the bank first.
 */
`timescale 1ns/10ps
`include "hc_regs_consts.vh"

module hc_ls_threshold_roothub_desc (
    input  wire        clock,
    input  wire        rst,
    input  wire        clk_en,
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_code,
    input  wire [31:0] wr_data,
    input  wire [13:0] frame_bits_left,
    input  wire        ls_request,
    output reg  [31:0] rd_data_r,
    output reg         rd_valid_r,
    output reg         cmd_error_r,
    output wire        ls_start,
    output reg         oc_reporting_on_r,
    output reg         oc_per_port_r,
    output reg         power_switched_r,
    output reg         power_per_port_r
);

    reg  [10:0] threshold_r;
    reg         threshold_locked_r;
    reg  [7:0]  settle_time_r;
    reg         oc_absent_r;
    reg         oc_sel_r;
    reg         pwr_absent_r;
    reg         pwr_sel_r;
    reg         reset_seen_r;
    reg  [31:0] rd_nxt;
    // Strobes decoded from this cycle's command
    wire        take_cmd;
    wire        lst_wr_hit;
    wire        rha_wr_hit;
    wire        rd_hit;
    wire        unknown_hit;

    ////////////////////////////////////////////////////////////////////
    // Command kinds; every consumer goes through one decoder so the
    // write enables, read mux and answer strobes agree on each code
    localparam [2:0] KIND_NONE   = 3'h0;
    localparam [2:0] KIND_LST_RD = 3'h1;
    localparam [2:0] KIND_LST_WR = 3'h2;
    localparam [2:0] KIND_RHA_RD = 3'h3;
    localparam [2:0] KIND_RHA_WR = 3'h4;

    function [2:0] decode_cmd;
        input [7:0] code;
        begin
            case (code)
                `CMD_LST_READ:  decode_cmd = KIND_LST_RD;
                `CMD_LST_WRITE: decode_cmd = KIND_LST_WR;
                `CMD_RHA_READ:  decode_cmd = KIND_RHA_RD;
                `CMD_RHA_WRITE: decode_cmd = KIND_RHA_WR;
                default:        decode_cmd = KIND_NONE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // A per-port select only means something while its feature exists;
    // shared by the overcurrent and the power mode outputs
    function mode_per_port;
        input absent;
        input sel;
        begin
            mode_per_port = !absent && sel;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Taken commands; nothing is taken while the clock enable is low
    assign take_cmd    = clk_en && cmd_valid;
    assign lst_wr_hit  = take_cmd && decode_cmd(cmd_code) == KIND_LST_WR;
    assign rha_wr_hit  = take_cmd && decode_cmd(cmd_code) == KIND_RHA_WR;
    assign rd_hit      = take_cmd &&
                         (decode_cmd(cmd_code) == KIND_LST_RD ||
                          decode_cmd(cmd_code) == KIND_RHA_RD);
    assign unknown_hit = take_cmd && decode_cmd(cmd_code) == KIND_NONE;

    ////////////////////////////////////////////////////////////////////
    // Assemble the descriptor word; reserved and fixed bits are constant
    function [31:0] rha_word;
        input [7:0] settle;
        input       oc_abs;
        input       oc_sel;
        input       pw_abs;
        input       pw_sel;
        begin
            rha_word = 32'h0000_0000;
            rha_word[`RHA_SETTLE_MSB:`RHA_SETTLE_LSB] = settle;
            rha_word[`RHA_OC_ABSENT]    = oc_abs;
            rha_word[`RHA_OC_PER_PORT]  = oc_sel;
            rha_word[`RHA_COMPOUND]     = 1'b0;
            rha_word[`RHA_PWR_ABSENT]   = pw_abs;
            rha_word[`RHA_PWR_PER_PORT] = pw_sel;
            rha_word[`RHA_PORTS_MSB:0]  = `RHA_PORTS_VALUE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Threshold: first write after reset sets it, later writes dropped.
    // Locking guards against a driver that rewrites it by mistake.
    // A second reset is the only way to reopen it.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            threshold_r        <= `LST_RESET;
            threshold_locked_r <= 1'b0;
        end else if (clk_en) begin
            if (lst_wr_hit && !threshold_locked_r) begin
                threshold_r        <= wr_data[`LST_MSB:0];
                threshold_locked_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Descriptor: writable in any host state, no state gating at all.
    // Overcurrent mode follows power mode after reset, in the first enabled cycle.
    // The bank has no host-state input, so a write is never held off.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            settle_time_r <= `RHA_SETTLE_RESET;
            oc_absent_r   <= `RHA_OC_ABS_RESET;
            oc_sel_r      <= 1'b0;
            pwr_absent_r  <= `RHA_PWR_ABS_RESET;
            pwr_sel_r     <= `RHA_PSM_RESET;
            reset_seen_r  <= 1'b0;
        end else if (clk_en) begin
            reset_seen_r <= 1'b1;
            if (rha_wr_hit) begin
                settle_time_r <=
                    wr_data[`RHA_SETTLE_MSB:`RHA_SETTLE_LSB];
                oc_absent_r   <= wr_data[`RHA_OC_ABSENT];
                oc_sel_r      <= wr_data[`RHA_OC_PER_PORT];
                pwr_absent_r  <= wr_data[`RHA_PWR_ABSENT];
                pwr_sel_r     <= wr_data[`RHA_PWR_PER_PORT];
            end else if (!reset_seen_r) begin
                oc_sel_r <= pwr_sel_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read mux; unknown codes return zero and flag an error
    always @* begin
        case (decode_cmd(cmd_code))
            KIND_LST_RD: rd_nxt = {21'h0, threshold_r};
            KIND_RHA_RD: rd_nxt = rha_word(settle_time_r, oc_absent_r,
                                      oc_sel_r, pwr_absent_r,
                                      pwr_sel_r);
            default:       rd_nxt = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Read answer one cycle after the command; the data word stays put
    // until the next taken command so a slow reader still finds it
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_r  <= 32'h0000_0000;
            rd_valid_r <= 1'b0;
        end else if (clk_en) begin
            rd_valid_r <= rd_hit;
            if (take_cmd) begin
                rd_data_r <= rd_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Codes that name no register here raise a one-cycle error pulse
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_error_r <= 1'b0;
        end else if (clk_en) begin
            cmd_error_r <= unknown_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decoded modes as levels, one cycle behind the register bits.
    // Per-port selects are masked while their feature is absent.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            oc_reporting_on_r <= 1'b0;
            oc_per_port_r     <= 1'b0;
            power_switched_r  <= 1'b0;
            power_per_port_r  <= 1'b0;
        end else if (clk_en) begin
            oc_reporting_on_r <= !oc_absent_r;
            oc_per_port_r     <= mode_per_port(oc_absent_r,
                                               oc_sel_r);
            power_switched_r  <= !pwr_absent_r;
            power_per_port_r  <= mode_per_port(pwr_absent_r,
                                               pwr_sel_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Commit comparison lives in its own small module; it registers
    // its answer, so a start follows the request by one cycle
    ls_commit_gate u_gate (
        .clock           (clock),
        .rst             (rst),
        .clk_en          (clk_en),
        .frame_bits_left (frame_bits_left),
        .threshold       (threshold_r),
        .ls_request      (ls_request),
        .ls_start_r      (ls_start)
    );

endmodule

// file: verification/hc_regs_chk.sv
/* Checker for the threshold and root hub descriptor register bank.
   Sees only the bank's ports; bound to every instance of the bank. */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module hc_regs_chk (
    input wire        clock,
    input wire        rst,
    input wire        clk_en,
    input wire        cmd_valid,
    input wire [7:0]  cmd_code,
    input wire [31:0] wr_data,
    input wire [13:0] frame_bits_left,
    input wire        ls_request,
    input wire [31:0] rd_data_r,
    input wire        rd_valid_r,
    input wire        cmd_error_r,
    input wire        ls_start,
    input wire        oc_reporting_on_r,
    input wire        oc_per_port_r,
    input wire        power_switched_r,
    input wire        power_per_port_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Taken commands, split into reads and writes; the rest are unknown
    wire tk = clk_en && cmd_valid;
    wire rd = tk && (cmd_code == 8'h11 || cmd_code == 8'h12);
    wire wr = tk && (cmd_code == 8'h91 || cmd_code == 8'h92);
    sequence s_dwr; tk && cmd_code == 8'h92; endsequence
    sequence s_idle; clk_en && !cmd_valid; endsequence
    property p_rdv; rd |=> rd_valid_r && !cmd_error_r; endproperty
    a_rdv: assert property (p_rdv)
        else $error("read command not answered");
    property p_err; tk && !rd && !wr |=> cmd_error_r && rd_data_r == 32'h0;
    endproperty
    a_err: assert property (p_err)
        else $error("unknown command not flagged");
    property p_thr; tk && cmd_code == 8'h11 |=> rd_data_r[31:11] == 21'h0;
    endproperty
    a_thr: assert property (p_thr)
        else $error("threshold upper bits not zero");
    property p_dsc; tk && cmd_code == 8'h12 |=> rd_data_r[23:13] == 11'h0
        && !rd_data_r[10] && rd_data_r[7:0] == 8'h02; endproperty
    a_dsc: assert property (p_dsc)
        else $error("descriptor fixed bits wrong");
    property p_ls; $rose(ls_start) |-> $past(ls_request); endproperty
    a_ls: assert property (p_ls)
        else $error("start without request");
    property p_oc; oc_per_port_r |-> oc_reporting_on_r; endproperty
    a_oc: assert property (p_oc)
        else $error("per-port report while reporting absent");
    property p_pw; power_per_port_r |-> power_switched_r; endproperty
    a_pw: assert property (p_pw)
        else $error("per-port power while not switched");
    // Mode outputs follow a descriptor write two cycles on
    property p_mode; s_dwr ##1 s_idle |=> oc_reporting_on_r ==
        !$past(wr_data[12], 2) && power_switched_r == !$past(wr_data[9], 2);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode outputs do not follow write");
    property p_rbk; s_dwr ##1 (tk && cmd_code == 8'h12) |=>
        rd_data_r[31:24] == $past(wr_data[31:24], 2)
        && rd_data_r[12:11] == $past(wr_data[12:11], 2); endproperty
    a_rbk: assert property (p_rbk)
        else $error("descriptor read-back differs");
endmodule
bind hc_ls_threshold_roothub_desc hc_regs_chk u_chk (.clock, .rst,
    .clk_en, .cmd_valid, .cmd_code, .wr_data, .frame_bits_left,
    .ls_request, .rd_data_r, .rd_valid_r, .cmd_error_r, .ls_start,
    .oc_reporting_on_r, .oc_per_port_r, .power_switched_r,
    .power_per_port_r);

// file: verification/hc_ls_threshold_roothub_desc_tb_top.sv
/* Self-checking bench for the register bank.
   Drives the command port directly; clock enable held high. */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module hc_ls_threshold_roothub_desc_tb_top;
    logic        clock = 0, rst = 1, cmd_valid = 0, ls_request = 0;
    logic [7:0]  cmd_code = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic [13:0] frame_bits_left = 14'h0;
    wire  [31:0] rd_data_r;
    wire         rd_valid_r, cmd_error_r, ls_start;
    wire         oc_reporting_on_r, oc_per_port_r;
    wire         power_switched_r, power_per_port_r;
    int          num_errors = 0, n_compared = 0;
    logic [75:0] r;
    // Rows: command, write data, read data, mode outputs
    logic [75:0] rows [12] = '{{8'h11, 32'h0, 32'h628, 4'hF},
        {8'h12, 32'h0, 32'hFF000902, 4'hF}, {8'h91, 32'hFFFFF123, 36'hF},
        {8'h11, 32'h0, 32'h123, 4'hF}, {8'h91, 32'h456, 36'hF},
        {8'h11, 32'h0, 32'h123, 4'hF}, {8'h92, 32'hFFFFFFFF, 36'h0},
        {8'h12, 32'h0, 32'hFF001B02, 4'h0}, {8'h92, 32'h0A000900, 36'hF},
        {8'h12, 32'h0, 32'h0A000902, 4'hF}, {8'h92, 32'h1000, 36'h2},
        {8'h55, 32'h0, 32'h0, 4'h2}};
    hc_ls_threshold_roothub_desc dut (.clock, .rst, .clk_en(1'b1),
        .cmd_valid, .cmd_code, .wr_data, .frame_bits_left, .ls_request,
        .rd_data_r, .rd_valid_r, .cmd_error_r, .ls_start,
        .oc_reporting_on_r, .oc_per_port_r, .power_switched_r,
        .power_per_port_r);
    initial forever #50 clock = ~clock;
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task close_out;
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One-cycle strobe; data goes stale on purpose once released
    task cmd(input logic [7:0] c, input logic [31:0] d);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        wr_data <= d;
        @(posedge clock);
        cmd_valid <= 1'b0;
        wr_data <= ~d;
        #1;
    endtask
    initial begin
        #100000 num_errors++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            cmd(r[75:68], r[67:36]);
            chk(rd_valid_r, r[75:68] == 8'h11 || r[75:68] == 8'h12);
            chk(cmd_error_r, r[75:68] != 8'h11 && r[75:68] != 8'h91 &&
                r[75:68] != 8'h12 && r[75:68] != 8'h92);
            if (!r[75]) chk(rd_data_r, r[35:4]);
            @(posedge clock);
            #1 chk({oc_reporting_on_r, oc_per_port_r, power_switched_r,
                power_per_port_r}, r[3:0]);
        end
        // Back-to-back write then read; bit 11 set after being cleared
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_code <= 8'h92;
        wr_data <= 32'h05000900;
        @(posedge clock);
        cmd_code <= 8'h12;
        @(posedge clock);
        cmd_valid <= 1'b0;
        #1 chk(rd_data_r, 32'h05000902);
        chk({oc_reporting_on_r, oc_per_port_r, power_switched_r,
            power_per_port_r}, 32'hF);
        // Threshold boundary: one below, equal, one above
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            frame_bits_left <= 14'h122 + 14'(i);
            ls_request <= 1'b1;
            @(posedge clock);
            #1 chk(ls_start, i > 0);
        end
        @(posedge clock);
        ls_request <= 1'b0;
        @(posedge clock);
        #1 chk(ls_start, 32'h0);
        // A second reset reopens the threshold for one write
        @(posedge clock) rst <= 1'b1;
        @(posedge clock) rst <= 1'b0;
        cmd(8'h11, 32'h0);
        chk(rd_data_r, 32'h628);
        cmd(8'h12, 32'h0);
        chk(rd_data_r, 32'hFF000902);
        chk({oc_reporting_on_r, oc_per_port_r, power_switched_r,
            power_per_port_r}, 32'hF);
        cmd(8'h91, 32'h7FF);
        cmd(8'h11, 32'h0);
        chk(rd_data_r, 32'h7FF);
        close_out;
    end
endmodule
